/* rtl/sfesi_pkg.sv */
// package: opcodes, status layout, sizes and timing of the flash command block
package sfesi_pkg;

   // opcodes
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
   localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_STATUS_ARM = 8'h50;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_JEDEC_ID = 8'h9F;
   localparam logic [7:0] OP_LEGACY_ID_A = 8'h90;
   localparam logic [7:0] OP_LEGACY_ID_B = 8'hAB;

   // status byte layout
   localparam int ST_BUSY = 0;
   localparam int ST_LATCH = 1;
   localparam int ST_LEVEL_LO = 2;
   localparam int ST_LEVEL_HI = 5;
   localparam int ST_AAI = 6;
   localparam int ST_LOCK = 7;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // frame lengths in whole bytes
   localparam logic [2:0] SINGLE_FRAME_BYTES = 3'h1;
   localparam logic [2:0] STATUS_WRITE_FRAME_BYTES = 3'h2;
   localparam logic [2:0] ADDR_FRAME_BYTES = 3'h4;
   localparam logic [2:0] ADDR_FIRST_BYTE = 3'h1;
   localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;

   // region sizes as powers of two
   localparam logic [4:0] SECTOR_LOG2 = 5'h0C;
   localparam logic [4:0] BLOCK32_LOG2 = 5'h0F;
   localparam logic [4:0] BLOCK64_LOG2 = 5'h10;
   localparam logic [4:0] LEVEL_STEP_LOG2 = 5'h0F;

   // timing
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned SECTOR_ERASE_TIME_US = 25000;
   localparam int unsigned BLOCK_ERASE_TIME_US = 25000;
   localparam int unsigned ARRAY_ERASE_TIME_US = 50000;
   localparam int unsigned STATUS_WRITE_TIME_US = 5;
   localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
   localparam int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int unsigned ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CLK_MHZ;
   localparam int unsigned STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * CLK_MHZ;

   typedef enum logic [1:0] {
      SFESI_ERASE_SECTOR = 2'h0,
      SFESI_ERASE_BLOCK32 = 2'h1,
      SFESI_ERASE_BLOCK64 = 2'h2,
      SFESI_ERASE_ARRAY = 2'h3
   } sfesi_erase_kind_type;

   typedef enum logic {
      SFESI_IDLE = 1'b0,
      SFESI_BUSY = 1'b1
   } sfesi_state_type;

   typedef struct packed {
      logic strobe;
      sfesi_erase_kind_type kind;
      logic [23:0] base;
   } sfesi_erase_req_type;

   typedef struct packed {
      logic [7:0] op;
      logic [23:0] addr;
      logic [7:0] data;
      logic [2:0] bytes;
      logic whole;
   } sfesi_frame_type;

endpackage

/* rtl/sfesi_core.sv */
// serial flash command block: erase, write latch, status and identification
`timescale 1ns/1ps

// Function
// - opcode 20H erases 4K sector, upper bits
// - protected sector or block erase is dropped
// - writes act on closing select rise only
// - opcode 52H erases 32K block
// - opcode D8H erases 64K block
// - 60H or C7H erases whole array
// - array erase dropped if anything protected
// - erases self-timed, busy bit shows progress
// - status read accepted at any time
// - status byte repeats until select rises
// - set latch command; status write clears it
// - clear command drops latch and auto flag
// - clear command never aborts running operation
// - arming lasts only for the next command
// - status write changes level and lock only
// - locked with protect pin low: ignore write
// - protect pin low: lock never clears
// - unlocked or pin high: level and lock writable
// - 9FH returns maker byte then device code
// - legacy ident alternates bytes until select rises
// - status read 05H, clear latch 04H
module sfesi_core #(
   parameter int ADDR_W = 20,
   // identification values are arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] TYPE_ID = 8'h3C,
   parameter logic [7:0] CAPACITY_ID = 8'h14,
   parameter int unsigned SECTOR_ERASE_CYCLES = sfesi_pkg::SECTOR_ERASE_CYC,
   parameter int unsigned BLOCK_ERASE_CYCLES = sfesi_pkg::BLOCK_ERASE_CYC,
   parameter int unsigned ARRAY_ERASE_CYCLES = sfesi_pkg::ARRAY_ERASE_CYC
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic chip_sel_n,
   input wire logic serial_in,
   input wire logic write_protect_n,
   output logic serial_out,
   output logic serial_out_en,
   output logic [7:0] status_view,
   output logic busy,
   output sfesi_pkg::sfesi_erase_req_type erase_req
);

   localparam int unsigned MAX_CYC =
      (ARRAY_ERASE_CYCLES > SECTOR_ERASE_CYCLES) ?
      ((ARRAY_ERASE_CYCLES > BLOCK_ERASE_CYCLES) ?
         ARRAY_ERASE_CYCLES : BLOCK_ERASE_CYCLES) :
      ((SECTOR_ERASE_CYCLES > BLOCK_ERASE_CYCLES) ?
         SECTOR_ERASE_CYCLES : BLOCK_ERASE_CYCLES);
   localparam int CNT_W = $clog2(MAX_CYC + 1);

   generate
      if (ADDR_W < 17 || ADDR_W > 24)
      begin : g_bad_addr
         $error("ADDR_W must lie between 17 and 24");
      end
      if (SECTOR_ERASE_CYCLES < 1 || BLOCK_ERASE_CYCLES < 1 ||
         ARRAY_ERASE_CYCLES < 1 ||
         sfesi_pkg::STATUS_WRITE_CYC > MAX_CYC)
      begin : g_bad_time
         $error("erase cycle counts out of range");
      end
   endgenerate

   // link side: shift in, bit and byte counts, cleared while deselected
   logic [2:0] bit_cnt;
   logic [2:0] byte_cnt;
   logic [6:0] shift_in;
   logic byte_toggle;
   logic [7:0] stat_meta;
   logic [7:0] stat_link;
   logic frame_toggle;
   sfesi_pkg::sfesi_frame_type frame;

   wire byte_end = bit_cnt == 3'h7;
   wire [7:0] rx_byte = {shift_in, serial_in};
   wire [2:0] next_bit_cnt = bit_cnt + 3'h1;
   wire [2:0] next_byte_cnt = (byte_end && byte_cnt != 3'h7) ?
      byte_cnt + 3'h1 : byte_cnt;
   wire first_edge = byte_cnt == 3'h0 && bit_cnt == 3'h0;
   wire addr_byte = byte_end && byte_cnt >= sfesi_pkg::ADDR_FIRST_BYTE &&
      byte_cnt <= sfesi_pkg::ADDR_LAST_BYTE;

   always_ff @(posedge serial_clk or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         bit_cnt <= 3'h0;
         byte_cnt <= 3'h0;
         shift_in <= 7'h00;
         byte_toggle <= 1'b0;
         stat_meta <= 8'h00;
         stat_link <= 8'h00;
      end
      else
      begin
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shift_in <= rx_byte[6:0];
         if (byte_end)
            byte_toggle <= ~byte_toggle;
         stat_meta <= status_view;
         stat_link <= stat_meta;
      end
   end

   // frame record survives the closing select rise for the system side
   always_ff @(posedge serial_clk or posedge reset)
   begin
      if (reset)
      begin
         frame <= '0;
         frame_toggle <= 1'b0;
      end
      else
      begin
         if (first_edge)
            frame_toggle <= ~frame_toggle;
         frame.bytes <= next_byte_cnt;
         frame.whole <= next_bit_cnt == 3'h0;
         if (byte_end && byte_cnt == 3'h0)
            frame.op <= rx_byte;
         if (byte_end && byte_cnt == sfesi_pkg::ADDR_FIRST_BYTE)
            frame.data <= rx_byte;
         if (addr_byte)
            frame.addr <= {frame.addr[15:0], rx_byte};
      end
   end

   // response selection
   wire is_status_rd = frame.op == sfesi_pkg::OP_STATUS_READ;
   wire is_jedec = frame.op == sfesi_pkg::OP_JEDEC_ID;
   wire is_legacy = frame.op == sfesi_pkg::OP_LEGACY_ID_A ||
      frame.op == sfesi_pkg::OP_LEGACY_ID_B;
   wire [7:0] jedec_byte = (byte_cnt == 3'h1) ? MAKER_ID :
      (byte_cnt == 3'h2) ? TYPE_ID :
      (byte_cnt == 3'h3) ? CAPACITY_ID : 8'h00;
   // address bit 0 picks which code leads the stream
   wire [7:0] legacy_byte = (byte_toggle ^ frame.addr[0]) ?
      CAPACITY_ID : MAKER_ID;
   wire legacy_on = is_legacy && byte_cnt >= sfesi_pkg::ADDR_FRAME_BYTES;
   wire after_op = byte_cnt != 3'h0;
   wire tx_on = after_op && (is_status_rd || is_jedec || legacy_on);
   wire [7:0] tx_byte = !after_op ? 8'h00 :
      is_status_rd ? stat_link :
      is_jedec ? jedec_byte :
      legacy_on ? legacy_byte : 8'h00;

   // output changes on the falling edge, silent once select rises
   always_ff @(negedge serial_clk or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         serial_out <= 1'b0;
         serial_out_en <= 1'b0;
      end
      else
      begin
         serial_out <= tx_byte[~bit_cnt];
         serial_out_en <= tx_on;
      end
   end

   // system side: synchronisers
   logic sel_meta;
   logic sel_sync;
   logic sel_last;
   logic wp_meta;
   logic wp_sync;
   logic tog_meta;
   logic tog_sync;
   logic tog_seen;

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
         sel_last <= 1'b1;
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
         tog_meta <= 1'b0;
         tog_sync <= 1'b0;
         tog_seen <= 1'b0;
      end
      else
      begin
         sel_meta <= chip_sel_n;
         sel_sync <= sel_meta;
         sel_last <= sel_sync;
         wp_meta <= write_protect_n;
         wp_sync <= wp_meta;
         tog_meta <= frame_toggle;
         tog_sync <= tog_meta;
         if (sel_sync && !sel_last)
            tog_seen <= tog_sync;
      end
   end

   // a frame ends on a select rise that followed clocked bits
   wire frame_end = sel_sync && !sel_last && tog_sync != tog_seen;
   wire go = frame_end && frame.whole;
   wire [7:0] op = frame.op;
   wire one_byte = go && frame.bytes == sfesi_pkg::SINGLE_FRAME_BYTES;
   wire two_byte = go && frame.bytes == sfesi_pkg::STATUS_WRITE_FRAME_BYTES;
   wire addr_full = go && frame.bytes >= sfesi_pkg::ADDR_FRAME_BYTES;

   wire c_set = one_byte && op == sfesi_pkg::OP_SET_LATCH;
   wire c_clear = one_byte && op == sfesi_pkg::OP_CLEAR_LATCH;
   wire c_arm = one_byte && op == sfesi_pkg::OP_STATUS_ARM;
   wire c_swr = two_byte && op == sfesi_pkg::OP_STATUS_WRITE;
   wire c_sector = addr_full && op == sfesi_pkg::OP_SECTOR_ERASE;
   wire c_blk32 = addr_full && op == sfesi_pkg::OP_BLOCK32_ERASE;
   wire c_blk64 = addr_full && op == sfesi_pkg::OP_BLOCK64_ERASE;
   wire c_array = one_byte && (op == sfesi_pkg::OP_ARRAY_ERASE_A ||
      op == sfesi_pkg::OP_ARRAY_ERASE_B);
   wire c_region = c_sector || c_blk32 || c_blk64;

   // status state
   logic write_latch;
   logic arm;
   logic auto_increment_program_flag;
   logic [3:0] level;
   logic lock;
   sfesi_pkg::sfesi_state_type state;
   sfesi_pkg::sfesi_state_type next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;

   // region of the addressed erase
   wire [4:0] span_log2 = c_sector ? sfesi_pkg::SECTOR_LOG2 :
      c_blk32 ? sfesi_pkg::BLOCK32_LOG2 :
      sfesi_pkg::BLOCK64_LOG2;
   wire [ADDR_W:0] unit = (ADDR_W + 1)'(1);
   wire [ADDR_W:0] span_full = (unit << span_log2) - unit;
   wire [ADDR_W-1:0] span_mask = span_full[ADDR_W-1:0];
   wire [ADDR_W-1:0] base = frame.addr[ADDR_W-1:0] & ~span_mask;
   wire [ADDR_W:0] last = {1'b0, base | span_mask};

   // protected top region grows by powers of two with the level
   wire [4:0] level_sh = {1'b0, level} + sfesi_pkg::LEVEL_STEP_LOG2;
   wire [ADDR_W:0] whole_size = unit << ADDR_W;
   wire level_all = level_sh >= 5'(ADDR_W);
   wire [ADDR_W:0] prot_size = level_all ? whole_size : unit << level_sh;
   wire [ADDR_W:0] prot_start = whole_size - prot_size;
   wire any_prot = level != 4'h0;
   wire prot_hit = any_prot && last >= prot_start;

   // launch decisions
   wire idle = state == sfesi_pkg::SFESI_IDLE;
   wire writable = write_latch && idle;
   wire do_region = c_region && writable && !prot_hit;
   wire do_array = c_array && writable && !any_prot;
   wire swr_allowed = wp_sync || !lock;
   wire do_swr = c_swr && (write_latch || arm) && idle && swr_allowed;
   wire launch = do_region || do_array || do_swr;

   // timer counts down to zero, so it loads one less than the length
   wire [CNT_W-1:0] load = do_swr ?
      CNT_W'(sfesi_pkg::STATUS_WRITE_CYC - 1) :
      do_array ? CNT_W'(ARRAY_ERASE_CYCLES - 1) :
      c_sector ? CNT_W'(SECTOR_ERASE_CYCLES - 1) :
      CNT_W'(BLOCK_ERASE_CYCLES - 1);

   // kind of the launched erase, sent along with the strobe
   sfesi_pkg::sfesi_erase_kind_type kind;
   assign kind = do_array ? sfesi_pkg::SFESI_ERASE_ARRAY :
      c_sector ? sfesi_pkg::SFESI_ERASE_SECTOR :
      c_blk32 ? sfesi_pkg::SFESI_ERASE_BLOCK32 :
      sfesi_pkg::SFESI_ERASE_BLOCK64;

   // next values of status bits
   // a status write frame drops the latch even when it is refused
   wire latch_drop = c_clear || c_swr || do_region || do_array;
   wire next_write_latch = c_set ? 1'b1 :
      latch_drop ? 1'b0 : write_latch;
   wire next_arm = c_arm ? 1'b1 : frame_end ? 1'b0 : arm;
   wire next_aai = c_clear ? 1'b0 : auto_increment_program_flag;
   wire [3:0] next_level = do_swr ?
      frame.data[sfesi_pkg::ST_LEVEL_HI:sfesi_pkg::ST_LEVEL_LO] :
      level;
   wire next_lock = do_swr ? frame.data[sfesi_pkg::ST_LOCK] :
      lock;

   // busy timer; a clear command leaves it running
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         sfesi_pkg::SFESI_IDLE:
            if (launch)
            begin
               next_state = sfesi_pkg::SFESI_BUSY;
               next_cnt = load;
            end
         sfesi_pkg::SFESI_BUSY:
            if (cnt == '0)
               next_state = sfesi_pkg::SFESI_IDLE;
            else
               next_cnt = cnt - 1'b1;
         default:
            next_state = sfesi_pkg::SFESI_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         write_latch <= sfesi_pkg::STATUS_RESET[sfesi_pkg::ST_LATCH];
         arm <= 1'b0;
         auto_increment_program_flag <= sfesi_pkg::STATUS_RESET[sfesi_pkg::ST_AAI];
         level <=
            sfesi_pkg::STATUS_RESET[sfesi_pkg::ST_LEVEL_HI:
               sfesi_pkg::ST_LEVEL_LO];
         lock <= sfesi_pkg::STATUS_RESET[sfesi_pkg::ST_LOCK];
      end
      else
      begin
         write_latch <= next_write_latch;
         arm <= next_arm;
         auto_increment_program_flag <= next_aai;
         level <= next_level;
         lock <= next_lock;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state <= sfesi_pkg::SFESI_IDLE;
         cnt <= '0;
         busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         busy <= next_state == sfesi_pkg::SFESI_BUSY;
      end
   end

   // erase request to the array, one pulse per launched erase
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
         erase_req <= '0;
      else
      begin
         erase_req.strobe <= do_region || do_array;
         if (do_region || do_array)
         begin
            erase_req.kind <= kind;
            erase_req.base <= do_array ? 24'h000000 : 24'(base);
         end
      end
   end

   // status byte as a status read shows it
   assign status_view = {lock, auto_increment_program_flag, level, write_latch, busy};

endmodule

/* bench/sfesi_sva.sv */
// assertions on the ports of the flash command block
`timescale 1ns/1ps
module sfesi_sva #(
   parameter int unsigned SECTOR_ERASE_CYCLES = 300,
   parameter int unsigned BLOCK_ERASE_CYCLES = 400,
   parameter int unsigned ARRAY_ERASE_CYCLES = 500
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic chip_sel_n,
   input wire logic write_protect_n,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic [7:0] status_view,
   input wire logic busy,
   input wire sfesi_pkg::sfesi_erase_req_type erase_req
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   int unsigned run;
   int unsigned exp_len;
   wire logic is_array = erase_req.kind == sfesi_pkg::SFESI_ERASE_ARRAY;
   wire logic is_sector = erase_req.kind == sfesi_pkg::SFESI_ERASE_SECTOR;
   // busy cycles of the running operation
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         run <= 0;
      else
         run <= busy ? run + 1 : 0;
   // length the running operation should have
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         exp_len <= sfesi_pkg::STATUS_WRITE_CYC;
      else if (erase_req.strobe)
         exp_len <= is_array ? ARRAY_ERASE_CYCLES :
            is_sector ? SECTOR_ERASE_CYCLES : BLOCK_ERASE_CYCLES;
      else if (!busy)
         exp_len <= sfesi_pkg::STATUS_WRITE_CYC;
   sequence s_launch;
      erase_req.strobe && $rose(busy);
   endsequence
   sequence s_settled;
      !erase_req.strobe && busy;
   endsequence
   property p_strobe_busy;
      erase_req.strobe |-> $rose(busy);
   endproperty
   a_strobe_busy: assert property (p_strobe_busy)
      else $error("strobe without busy rise");
   property p_strobe_one;
      s_launch |=> s_settled;
   endproperty
   a_strobe_one: assert property (p_strobe_one)
      else $error("strobe not a single pulse");
   property p_busy_bit;
      busy == status_view[sfesi_pkg::ST_BUSY];
   endproperty
   a_busy_bit: assert property (p_busy_bit)
      else $error("busy port and status bit differ");
   property p_idle_out;
      chip_sel_n |-> !serial_out_en && !serial_out;
   endproperty
   a_idle_out: assert property (p_idle_out)
      else $error("data out active while deselected");
   property p_launch_rise;
      $rose(busy) |-> chip_sel_n && $past(chip_sel_n, 3);
   endproperty
   a_launch_rise: assert property (p_launch_rise)
      else $error("operation launched while selected");
   property p_latch_drop;
      s_launch |=> !status_view[sfesi_pkg::ST_LATCH];
   endproperty
   a_latch_drop: assert property (p_latch_drop)
      else $error("write latch kept after erase launch");
   property p_latch_need;
      s_launch |-> $past(status_view[sfesi_pkg::ST_LATCH]);
   endproperty
   a_latch_need: assert property (p_latch_need)
      else $error("erase launched without write latch");
   property p_auto_low;
      !status_view[sfesi_pkg::ST_AAI];
   endproperty
   a_auto_low: assert property (p_auto_low)
      else $error("auto increment flag set");
   property p_lock_hold;
      $fell(status_view[sfesi_pkg::ST_LOCK]) |-> $past(write_protect_n, 3);
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("lock cleared with protect pin low");
   property p_busy_len;
      $fell(busy) |-> run == exp_len;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");
endmodule

bind sfesi_core sfesi_sva #(
   .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
   .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES),
   .ARRAY_ERASE_CYCLES(ARRAY_ERASE_CYCLES)
) u_sva (.clk_sys(clk_sys), .reset(reset), .chip_sel_n(chip_sel_n),
   .write_protect_n(write_protect_n), .serial_out(serial_out),
   .serial_out_en(serial_out_en), .status_view(status_view),
   .busy(busy), .erase_req(erase_req));

/* bench/sfesi_host.sv */
// host controller model driving the serial link
`timescale 1ns/1ps
module sfesi_host (
   output logic serial_clk,
   output logic chip_sel_n,
   output logic serial_in,
   input wire logic serial_out
);
   initial
   begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      serial_in = 1'b0;
   end
   // nb bytes of w sent, rb bits read back; clock stops between frames
   task automatic xfer(input logic [31:0] w, input int nb, input int rb,
      output logic [31:0] rx);
      int i;
      rx = 32'h0;
      #203;
      chip_sel_n = 1'b0;
      for (i = 0; i < nb * 8 + rb; i++)
      begin
         serial_in = i < nb * 8 ? w[31 - i] : ~serial_in;
         #24 serial_clk = 1'b1;
         if (i >= nb * 8)
            rx = {rx[30:0], serial_out};
         #24 serial_clk = 1'b0;
      end
      #24 chip_sel_n = 1'b1;
   endtask
endmodule

/* bench/tb_top.sv */
// self-checking bench for the flash command block
`timescale 1ns/1ps
module tb_top;
   logic clk_sys;
   logic reset;
   logic serial_clk;
   logic chip_sel_n;
   logic serial_in;
   logic write_protect_n;
   logic serial_out;
   logic serial_out_en;
   logic [7:0] status_view;
   logic busy;
   sfesi_pkg::sfesi_erase_req_type erase_req;
   sfesi_pkg::sfesi_erase_req_type got;
   int fail_count = 0;
   int checks_done = 0;
   int seed = 32'h182055f5;
   int en_cnt = 0;
   int en0;
   logic seen;
   logic [31:0] rx;
   logic [31:0] a;
   logic [7:0] d;
   logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
   sfesi_core #(.SECTOR_ERASE_CYCLES(300), .BLOCK_ERASE_CYCLES(400),
      .ARRAY_ERASE_CYCLES(500)) dut (.clk_sys(clk_sys), .reset(reset),
      .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
      .serial_in(serial_in), .write_protect_n(write_protect_n),
      .serial_out(serial_out), .serial_out_en(serial_out_en),
      .status_view(status_view), .busy(busy), .erase_req(erase_req));
   sfesi_host host (.serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
      .serial_in(serial_in), .serial_out(serial_out));
   // counts link clock rises at which the device drives data out
   always @(posedge serial_clk)
      if (serial_out_en === 1'b1)
         en_cnt++;
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize;
      if (fail_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one write-type frame, then watch for an erase launch
   task automatic send(input logic [31:0] w, input int nb);
      host.xfer(w, nb, 0, rx);
      seen = 1'b0;
      repeat (10)
      begin
         @(negedge clk_sys);
         if (erase_req.strobe === 1'b1)
         begin
            seen = 1'b1;
            got = erase_req;
         end
      end
   endtask
   task automatic idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("idle", 0, busy);
   endtask
   // armed status write of value v
   task automatic wrst(input logic [7:0] v);
      send(32'h50000000, 1);
      send({8'h01, v, 16'h0}, 2);
      idle();
   endtask
   function automatic logic [23:0] base_of(input int k, input logic [31:0] ad);
      logic [23:0] m;
      m = k == 0 ? 24'hFFF000 : k == 1 ? 24'hFF8000 : 24'hFF0000;
      return k > 2 ? 24'h0 : ad[23:0] & m & 24'h0FFFFF;
   endfunction
   initial
   begin
      #1000000;
      fail_count++;
      summarize();
   end
   initial
   begin
      reset = 1'b1;
      write_protect_n = 1'b1;
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("status", 8'h00, status_view);
      send(32'h20012345, 4);
      chk("no_latch", 0, seen);
      for (int i = 0; i < 5; i++)
      begin
         a = $random(seed);
         send(32'h06000000, 1);
         chk("latch", 8'h02, status_view);
         send({ops[i], a[23:0]}, i < 3 ? 4 : 1);
         chk("launch", 1, seen);
         chk("kind", i<3?i:3, got.kind);
         chk("base", base_of(i, a), got.base);
         en0 = en_cnt;
         host.xfer(32'h05000000, 1, 16, rx);
         chk("busy_read", 32'h0101, rx);
         chk("read_en", 16, en_cnt - en0);
         send(32'h04000000, 1);
         chk("still_busy", 1, busy);
         idle();
      end
      send(32'h06000000, 1);
      send(32'h04000000, 1);
      chk("cleared", 8'h00, status_view);
      send(32'hD8000000, 4);
      chk("no_erase", 0, seen);
      d = $random(seed);
      d[7] = 1'b0;
      wrst(d);
      chk("level", {2'b00, d[5:2], 2'b00}, status_view);
      send(32'h06000000, 1);
      send(32'h01040000, 2);
      chk("latch_gone", 0, status_view[1]);
      idle();
      chk("level1", 8'h04, status_view);
      send(32'h06000000, 1);
      send(32'h20FF0123, 4);
      chk("prot_sector", 0, seen);
      send(32'h06000000, 1);
      send(32'hC7000000, 1);
      chk("prot_array", 0, seen);
      send(32'h06000000, 1);
      send(32'h52008000, 4);
      chk("free_block", 1, seen);
      idle();
      send(32'h50000000, 1);
      host.xfer(32'h05000000, 1, 8, rx);
      send(32'h01000000, 2);
      chk("cancel", 8'h04, status_view);
      write_protect_n = 1'b0;
      wrst(8'h80);
      chk("lock_set", 8'h80, status_view);
      wrst(8'h00);
      chk("locked", 8'h80, status_view);
      write_protect_n = 1'b1;
      wrst(8'h00);
      chk("unlocked", 8'h00, status_view);
      en0 = en_cnt;
      host.xfer(32'h9F000000, 1, 32, rx);
      chk("jedec", 32'h5A3C1400, rx);
      chk("jedec_en", 32, en_cnt - en0);
      en0 = en_cnt;
      host.xfer(32'h90000000, 4, 32, rx);
      chk("legacy0", 32'h5A145A14, rx);
      chk("legacy_en", 32, en_cnt - en0);
      host.xfer(32'hAB000001, 4, 16, rx);
      chk("legacy1", 32'h145A, rx);
      summarize();
   end
endmodule
